// ### src/crb_pkg.sv
// Shared constants, codes and helpers for the bus and interrupt control block
`default_nettype none
package crb_pkg;

  // ==========================================================
  // Reset and start-up
  localparam logic [3:0] RESET_SEQ_CLKS = 4'h7;
  localparam logic [3:0] NMI_ARM_CLKS = 4'h2;
  localparam logic [19:0] RESET_VECTOR = 20'hffff0;

  // ==========================================================
  // Interrupt vectors
  localparam logic [7:0] NMI_TYPE = 8'h02;
  localparam int VEC_SHIFT = 2;
  localparam logic [9:0] VEC_TABLE_TOP = 10'h3ff;

  // ==========================================================
  // Cycle status codes, also used as the core request kind
  localparam logic [2:0] CS_ACK = 3'h0;
  localparam logic [2:0] CS_IO_RD = 3'h1;
  localparam logic [2:0] CS_IO_WR = 3'h2;
  localparam logic [2:0] CS_HALT = 3'h3;
  localparam logic [2:0] CS_FETCH = 3'h4;
  localparam logic [2:0] CS_MEM_RD = 3'h5;
  localparam logic [2:0] CS_MEM_WR = 3'h6;
  localparam logic [2:0] CS_PASSIVE = 3'h7;

  typedef enum logic [3:0] {
    BS_RESET, BS_IDLE, BS_T1, BS_T2, BS_T3, BS_TW, BS_T4,
    BS_HALT_ST, BS_HALT_ALE, BS_HALTED, BS_HOLD
  } crb_bus_e;

  function automatic logic crb_is_write(input logic [2:0] code);
    return code[1] & ~code[0];
  endfunction

  // Minimum-mode status lines: {io_or_mem_sel, xcvr_dir, status_zero_min}
  function automatic logic [2:0] crb_min_status(input logic [2:0] code);
    return {~code[2], code[1], code[0]};
  endfunction

  function automatic logic [9:0] crb_vec_ptr(input logic [7:0] vtype);
    return {vtype, 2'b00};
  endfunction

endpackage
`default_nettype wire

// ### src/crb_rst_seq.sv
// Reset pin synchroniser and post-reset start-up sequence
`default_nettype none
module crb_rst_seq (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cpu_reset,
  output logic in_reset,
  output logic first_clk,
  output logic seq_busy,
  output logic nmi_arm,
  output logic core_start
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic busy;
    logic arm;
    logic start;
    logic [3:0] cnt;
  } crb_rst_s;

  crb_rst_s r_r;
  crb_rst_s r_nxt;

  // ==========================================================
  // Sequence
  always_comb begin
    r_nxt = r_r;
    r_nxt.s1 = cpu_reset;
    r_nxt.s2 = r_r.s1;
    r_nxt.prev = r_r.s2;
    r_nxt.start = 1'b0;
    if (r_r.s2) begin
      r_nxt.busy = 1'b0;
      r_nxt.arm = 1'b0;
      r_nxt.cnt = 4'h0;
    end else if (r_r.prev) begin
      r_nxt.busy = 1'b1;
      r_nxt.cnt = 4'h1;
    end else if (r_r.busy) begin
      r_nxt.cnt = r_r.cnt + 4'h1;
      if (r_r.cnt == crb_pkg::NMI_ARM_CLKS) begin
        r_nxt.arm = 1'b1;
      end
      if (r_r.cnt == crb_pkg::RESET_SEQ_CLKS) begin
        r_nxt.busy = 1'b0;
        r_nxt.start = 1'b1;
      end
    end
  end

  // Power-on looks like reset held until the pin is seen
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_r <= '{s1: 1'b1, s2: 1'b1, prev: 1'b1, busy: 1'b0, arm: 1'b0,
               start: 1'b0, cnt: 4'h0};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign in_reset = r_r.s2;
  assign first_clk = r_r.s2 & ~r_r.prev;
  assign seq_busy = r_r.busy;
  assign nmi_arm = r_r.arm;
  assign core_start = r_r.start;

endmodule
`default_nettype wire

// ### src/crb_nmi_det.sv
// Edge latch for the non-maskable request, with its own synchroniser
`default_nettype none
module crb_nmi_det (
  input wire logic clk,
  input wire logic resetn,
  input wire logic nonmaskable_irq,
  input wire logic arm,
  input wire logic clear,
  output logic pending
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic pend;
  } crb_nmi_s;

  crb_nmi_s n_r;
  crb_nmi_s n_nxt;
  logic rise;

  // ==========================================================
  // Edge capture; a new edge beats a clear in the same cycle
  always_comb begin
    n_nxt = n_r;
    n_nxt.s1 = nonmaskable_irq;
    n_nxt.s2 = n_r.s1;
    n_nxt.prev = n_r.s2;
    rise = n_r.s2 & ~n_r.prev;
    n_nxt.pend = arm & (rise | (n_r.pend & ~clear));
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      n_r <= '0;
    end else begin
      n_r <= n_nxt;
    end
  end

  assign pending = n_r.pend;

endmodule
`default_nettype wire

// ### src/crb_bus_ctrl.sv
// Processor-side reset, interrupt, hold, lock and bus-cycle control
// How it works
// - Reset rising stops all activity; nothing runs while it stays high.
// - Synchronised reset; fetch starts at FFFF0 seven clocks after its fall.
// - NMI before second clock after reset ignored; later ones wait.
// - Hold request pending after reset is granted before the first fetch.
// - In reset pins float; status idle one clock; strobe, grant low.
// - Vector table: 256 four-byte entries at 0..3FF, typed by a byte.
// - NMI is rising-edge detected, outranks the maskable request, type 2.
// - Each NMI edge once armed is latched and serviced at the next boundary.
// - Maskable request sampled each clock, enable-gated, seen clock before.
// - Response clears the enable flag and reports its old value.
// - Two back-to-back acknowledge cycles; no hold until the second ends.
// - Maximum mode: lock from T2 of first to T2 of second acknowledge; here it starts at T3 of the first.
// - Controller drives type byte in second acknowledge; pointer is type*4.
// - Acknowledge uses read timing, ack strobe instead, address floated.
// - Halt: min-mode strobe one clock late with halt status lines.
// - Halt survives a hold and is reissued; only interrupt or reset exit.
// - Lock follows the prefix, ends after next instruction's last cycle.
// - Wait loops until test pin low; a hold floats all drivers.
// - Read: strobe in T1, bus floats at T2 with read strobe.
// - Write: data from T2 through T4, write strobe T2, T3, waits.
// - Cycles last T1..T4; not-ready inserts waits between T3 and T4.
`default_nettype none
module crb_bus_ctrl (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cpu_reset,
  input wire logic config_strap,
  input wire logic nonmaskable_irq,
  input wire logic maskable_irq_req,
  input wire logic hold_req,
  input wire logic ready,
  input wire logic wait_release_n,
  input wire logic req_grant_line_i,
  output logic req_grant_line_o,
  output logic req_grant_line_oe,
  input wire logic [7:0] muxed_low_bus_i,
  output logic [7:0] muxed_low_bus_o,
  output logic muxed_low_bus_oe,
  output logic [7:0] mid_addr_bus,
  output logic mid_addr_oe,
  output logic [3:0] high_addr_status,
  output logic high_addr_oe,
  output logic addr_latch_strobe,
  output logic hold_grant,
  output logic read_strobe_n,
  output logic store_strobe_n,
  output logic irq_ack_n,
  output logic io_or_mem_sel,
  output logic xcvr_dir,
  output logic xcvr_enable_n,
  output logic status_zero_min,
  output logic ctl_oe,
  output logic [2:0] cycle_status,
  output logic cycle_status_oe,
  output logic bus_exclusive_n,
  output logic bus_exclusive_oe,
  input wire logic core_req,
  input wire logic [2:0] core_kind,
  input wire logic [19:0] core_addr,
  input wire logic [7:0] core_wdata,
  input wire logic [1:0] core_seg,
  input wire logic core_lock_prefix,
  input wire logic core_lock_last,
  output logic core_ready,
  output logic core_done,
  output logic [7:0] core_rdata,
  output logic core_start,
  input wire logic core_boundary,
  input wire logic core_if_wr,
  input wire logic core_if_val,
  output logic irq_enable_flag,
  output logic core_if_pushed,
  output logic core_irq_take,
  output logic [9:0] core_irq_ptr,
  input wire logic core_waiting,
  output logic core_wait_done
);

  typedef struct packed {
    crb_pkg::crb_bus_e st;
    logic [2:0] kind;
    logic [19:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [1:0] seg;
    logic last;
    logic done;
    logic ack_seq;
    logic ack_second;
    logic ack_lock;
    logic lock;
    logic if_flag;
    logic if_before;
    logic maskable_irq_req_q;
    logic hold_pend;
    logic gnt;
    logic halted;
    logic take;
    logic [9:0] ptr;
    logic wait_done;
  } crb_ctl_s;

  crb_ctl_s c_r;
  crb_ctl_s c_nxt;

  logic in_reset;
  logic first_clk;
  logic seq_busy;
  logic nmi_arm;
  logic nmi_pend;
  logic nmi_clear;
  logic min_mode;
  logic drive_en;
  logic in_cycle;
  logic is_ack;
  logic is_wr;
  logic hold_ok;
  logic hold_end;
  logic hold_ask;
  logic service_pt;
  logic [2:0] code_now;
  logic [2:0] min_st;

  // ==========================================================
  // Reset sequencing and NMI capture
  crb_rst_seq u_rst (
    .clk(clk),
    .resetn(resetn),
    .cpu_reset(cpu_reset),
    .in_reset(in_reset),
    .first_clk(first_clk),
    .seq_busy(seq_busy),
    .nmi_arm(nmi_arm),
    .core_start(core_start)
  );

  crb_nmi_det u_nmi (
    .clk(clk),
    .resetn(resetn),
    .nonmaskable_irq(nonmaskable_irq),
    .arm(nmi_arm),
    .clear(nmi_clear),
    .pending(nmi_pend)
  );

  assign min_mode = config_strap;
  assign in_cycle = (c_r.st == crb_pkg::BS_T1) ||
                    (c_r.st == crb_pkg::BS_T2) ||
                    (c_r.st == crb_pkg::BS_T3) ||
                    (c_r.st == crb_pkg::BS_TW) ||
                    (c_r.st == crb_pkg::BS_T4);
  assign is_ack = c_r.kind == crb_pkg::CS_ACK;
  assign is_wr = crb_pkg::crb_is_write(c_r.kind);
  // Locked sequences and the acknowledge pair keep the bus
  assign hold_ok = c_r.hold_pend & ~c_r.lock & ~c_r.ack_seq;
  // Max mode: a low pulse on the shared line asks or hands back
  assign hold_ask = min_mode ? hold_req : ~req_grant_line_i;
  assign hold_end = min_mode ? ~hold_req : (~c_r.gnt & ~req_grant_line_i);
  assign service_pt = core_boundary || (c_r.st == crb_pkg::BS_HALTED);

  // ==========================================================
  // Next-state logic
  always_comb begin
    c_nxt = c_r;
    nmi_clear = 1'b0;
    c_nxt.done = 1'b0;
    c_nxt.take = 1'b0;
    c_nxt.gnt = 1'b0;
    c_nxt.maskable_irq_req_q = maskable_irq_req;
    c_nxt.wait_done = core_waiting & ~wait_release_n;
    if (core_lock_prefix) begin
      c_nxt.lock = 1'b1;
    end
    if (core_if_wr) begin
      c_nxt.if_flag = core_if_val;
    end
    if (hold_ask && c_r.st != crb_pkg::BS_HOLD) begin
      c_nxt.hold_pend = 1'b1;
    end else if (min_mode && !hold_req) begin
      c_nxt.hold_pend = 1'b0;
    end

    // Interrupt entry at a boundary or while halted
    if (service_pt && !c_r.ack_seq) begin
      if (nmi_pend) begin
        nmi_clear = 1'b1;
        c_nxt.take = 1'b1;
        c_nxt.ptr = crb_pkg::crb_vec_ptr(crb_pkg::NMI_TYPE);
        c_nxt.if_before = c_r.if_flag;
        c_nxt.if_flag = 1'b0;
        c_nxt.halted = 1'b0;
      end else if (c_r.maskable_irq_req_q && c_r.if_flag) begin
        c_nxt.ack_seq = 1'b1;
        c_nxt.ack_second = 1'b0;
        c_nxt.if_before = c_r.if_flag;
        c_nxt.if_flag = 1'b0;
        c_nxt.halted = 1'b0;
      end
    end

    unique case (c_r.st)
      crb_pkg::BS_RESET: begin
        if (!seq_busy && !in_reset) begin
          c_nxt.st = crb_pkg::BS_IDLE;
        end
      end
      crb_pkg::BS_IDLE: begin
        if (hold_ok) begin
          c_nxt.st = crb_pkg::BS_HOLD;
          c_nxt.gnt = 1'b1;
        end else if (c_r.ack_seq) begin
          c_nxt.st = crb_pkg::BS_T1;
          c_nxt.kind = crb_pkg::CS_ACK;
          c_nxt.last = 1'b0;
        end else if (core_req) begin
          c_nxt.addr = core_addr;
          c_nxt.wdata = core_wdata;
          c_nxt.seg = core_seg;
          c_nxt.last = core_lock_last;
          c_nxt.kind = core_kind;
          if (core_kind == crb_pkg::CS_HALT) begin
            c_nxt.st = crb_pkg::BS_HALT_ST;
            c_nxt.halted = 1'b1;
          end else begin
            c_nxt.st = crb_pkg::BS_T1;
          end
        end
      end
      crb_pkg::BS_T1: begin
        c_nxt.st = crb_pkg::BS_T2;
      end
      crb_pkg::BS_T2: begin
        c_nxt.st = crb_pkg::BS_T3;
        if (is_ack) begin
          c_nxt.ack_lock = ~c_r.ack_second;
        end
      end
      crb_pkg::BS_T3, crb_pkg::BS_TW: begin
        if (ready) begin
          c_nxt.st = crb_pkg::BS_T4;
          c_nxt.rdata = muxed_low_bus_i;
        end else begin
          c_nxt.st = crb_pkg::BS_TW;
        end
      end
      crb_pkg::BS_T4: begin
        if (is_ack && !c_r.ack_second) begin
          c_nxt.st = crb_pkg::BS_T1;
          c_nxt.ack_second = 1'b1;
        end else begin
          c_nxt.st = crb_pkg::BS_IDLE;
          if (is_ack) begin
            c_nxt.ack_seq = 1'b0;
            c_nxt.ack_second = 1'b0;
            c_nxt.take = 1'b1;
            c_nxt.ptr = crb_pkg::crb_vec_ptr(c_r.rdata);
          end else begin
            c_nxt.done = 1'b1;
          end
          if (c_r.last && !core_lock_prefix) begin
            c_nxt.lock = 1'b0;
          end
        end
      end
      crb_pkg::BS_HALT_ST: begin
        c_nxt.st = crb_pkg::BS_HALT_ALE;
      end
      crb_pkg::BS_HALT_ALE: begin
        c_nxt.st = crb_pkg::BS_HALTED;
      end
      crb_pkg::BS_HALTED: begin
        if (!c_nxt.halted) begin
          c_nxt.st = crb_pkg::BS_IDLE;
        end else if (hold_ok) begin
          c_nxt.st = crb_pkg::BS_HOLD;
          c_nxt.gnt = 1'b1;
        end
      end
      crb_pkg::BS_HOLD: begin
        if (hold_end) begin
          c_nxt.hold_pend = 1'b0;
          // Reissue the halt indication after the hold
          c_nxt.st = c_r.halted ? crb_pkg::BS_HALT_ST
                                : crb_pkg::BS_IDLE;
        end
      end
    endcase

    // Reset forces the state, lock, acknowledge, halt and pulses idle, keeps a pending hold, and leaves the enable flag clear
    if (in_reset) begin
      c_nxt.st = crb_pkg::BS_RESET;
      c_nxt.ack_seq = 1'b0;
      c_nxt.ack_second = 1'b0;
      c_nxt.ack_lock = 1'b0;
      c_nxt.lock = 1'b0;
      c_nxt.if_flag = 1'b0;
      c_nxt.halted = 1'b0;
      c_nxt.take = 1'b0;
      c_nxt.done = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      c_r <= '{st: crb_pkg::BS_RESET, kind: crb_pkg::CS_PASSIVE,
               default: '0};
    end else begin
      c_r <= c_nxt;
    end
  end

  // ==========================================================
  // Pin decode
  // Nothing drives in reset, bar max-mode status on its first clock, or while the bus is handed away
  assign drive_en = ~in_reset && (c_r.st != crb_pkg::BS_HOLD);

  always_comb begin
    code_now = crb_pkg::CS_PASSIVE;
    if (in_cycle) begin
      code_now = c_r.kind;
    end else if (c_r.st == crb_pkg::BS_HALT_ST ||
                 c_r.st == crb_pkg::BS_HALT_ALE ||
                 c_r.st == crb_pkg::BS_HALTED) begin
      code_now = crb_pkg::CS_HALT;
    end
    min_st = crb_pkg::crb_min_status(code_now);
  end

  // ALE: T1 of normal cycles, one clock late for halt
  assign addr_latch_strobe = min_mode && drive_en &&
    ((c_r.st == crb_pkg::BS_T1) ||
     (c_r.st == crb_pkg::BS_HALT_ALE));
  assign hold_grant = min_mode && !in_reset &&
                      (c_r.st == crb_pkg::BS_HOLD);
  assign req_grant_line_o = 1'b0;
  assign req_grant_line_oe = ~min_mode & c_r.gnt;

  always_comb begin
    read_strobe_n = 1'b1;
    store_strobe_n = 1'b1;
    irq_ack_n = 1'b1;
    xcvr_enable_n = 1'b1;
    if (c_r.st == crb_pkg::BS_T2 || c_r.st == crb_pkg::BS_T3 ||
        c_r.st == crb_pkg::BS_TW) begin
      if (is_ack) begin
        irq_ack_n = 1'b0;
      end else if (is_wr) begin
        store_strobe_n = 1'b0;
      end else begin
        read_strobe_n = 1'b0;
      end
    end
    if (in_cycle && c_r.st != crb_pkg::BS_T1) begin
      xcvr_enable_n = 1'b0;
    end
  end

  assign io_or_mem_sel = min_st[2];
  assign xcvr_dir = min_st[1];
  assign status_zero_min = min_st[0];
  assign ctl_oe = min_mode & drive_en;

  // Status shows for T1, T2 and the first halt clock, passive otherwise
  assign cycle_status = (c_r.st == crb_pkg::BS_T3 ||
                         c_r.st == crb_pkg::BS_TW ||
                         c_r.st == crb_pkg::BS_T4 ||
                         c_r.st == crb_pkg::BS_HALT_ALE ||
                         c_r.st == crb_pkg::BS_HALTED ||
                         in_reset) ? crb_pkg::CS_PASSIVE : code_now;
  assign cycle_status_oe = ~min_mode & (drive_en | first_clk);

  assign bus_exclusive_n = ~(c_r.lock | c_r.ack_lock);
  assign bus_exclusive_oe = ~min_mode & drive_en;

  // Acknowledge leaves every address line floating
  assign muxed_low_bus_o = (c_r.st == crb_pkg::BS_T1) ? c_r.addr[7:0]
                                                      : c_r.wdata;
  assign muxed_low_bus_oe = drive_en && in_cycle && !is_ack &&
    ((c_r.st == crb_pkg::BS_T1) || is_wr);
  assign mid_addr_bus = c_r.addr[15:8];
  assign mid_addr_oe = drive_en && in_cycle && !is_ack;
  assign high_addr_status = (c_r.st == crb_pkg::BS_T1) ? c_r.addr[19:16]
                            : {1'b0, c_r.if_flag, c_r.seg};
  assign high_addr_oe = drive_en && in_cycle && !is_ack;

  // ==========================================================
  // Core side
  assign core_ready = (c_r.st == crb_pkg::BS_IDLE) && !in_reset &&
                      !c_r.ack_seq && !hold_ok;
  assign core_done = c_r.done;
  assign core_rdata = c_r.rdata;
  assign irq_enable_flag = c_r.if_flag;
  assign core_if_pushed = c_r.if_before;
  assign core_irq_take = c_r.take;
  assign core_irq_ptr = c_r.ptr;
  assign core_wait_done = c_r.wait_done;

endmodule
`default_nettype wire

// ### bench/crb_mem_model.sv
// Memory, I/O and interrupt controller model on the far side of the bus
`default_nettype none
module crb_mem_model (
  input wire logic clk,
  input wire logic [7:0] ad_o,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ack_n,
  input wire logic [3:0] waits,
  input wire logic [7:0] vtype,
  output logic [7:0] ad_i,
  output logic rdy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [16];
  logic [7:0] last;
  logic [3:0] adr, cnt;
  wire act = !rd_n || !ack_n || !wr_n;
  // ==========================================================
  // Device side
  // Not ready for the first waits clocks after a strobe opens
  assign rdy = !act || cnt > waits;
  // Released bus toggles so a stale value never passes for data
  assign ad_i = !ack_n ? vtype : !rd_n ? mem[adr] : ~last;
  always @(posedge clk) begin
    last <= ad_i;
    cnt <= act ? cnt + 4'h1 : 4'h0;
    if (ale) adr <= ad_o[3:0];
    if (!wr_n) mem[adr] <= ad_o;
  end
endmodule
`default_nettype wire

// ### bench/crb_bus_ctrl_asserts.sv
// Port-level checker for the bus and interrupt control block
`default_nettype none
module crb_bus_ctrl_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cpu_reset,
  input wire logic config_strap,
  input wire logic ready,
  input wire logic [7:0] muxed_low_bus_o,
  input wire logic muxed_low_bus_oe,
  input wire logic mid_addr_oe,
  input wire logic addr_latch_strobe,
  input wire logic hold_grant,
  input wire logic read_strobe_n,
  input wire logic store_strobe_n,
  input wire logic irq_ack_n,
  input wire logic io_or_mem_sel,
  input wire logic xcvr_dir,
  input wire logic status_zero_min,
  input wire logic ctl_oe,
  input wire logic core_req,
  input wire logic [2:0] core_kind,
  input wire logic [19:0] core_addr,
  input wire logic [7:0] core_wdata,
  input wire logic core_ready,
  input wire logic core_done,
  input wire logic [7:0] core_rdata,
  input wire logic core_start,
  input wire logic core_irq_take,
  input wire logic [9:0] core_irq_ptr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic take, rd_k, wr_k;
  assign take = core_req && core_ready;
  assign rd_k = core_kind == crb_pkg::CS_MEM_RD
    || core_kind == crb_pkg::CS_IO_RD || core_kind == crb_pkg::CS_FETCH;
  assign wr_k = core_kind == crb_pkg::CS_MEM_WR
    || core_kind == crb_pkg::CS_IO_WR;
  // ==========================================================
  // Reset and bus cycles
  rst_quiet_a: assert property (
    cpu_reset [*5] |-> !muxed_low_bus_oe && !mid_addr_oe && !ctl_oe
    && !addr_latch_strobe && !hold_grant)
    else $error("outputs active in reset");
  start_delay_a: assert property (
    $fell(cpu_reset) |-> !core_start [*7] ##[1:6] core_start)
    else $error("start pulse off time");
  cyc_len_a: assert property (
    take && core_kind != crb_pkg::CS_HALT
    |=> !core_done [*4] ##[1:8] core_done)
    else $error("bus cycle length wrong");
  rd_phase_a: assert property (
    take && rd_k && config_strap |=> addr_latch_strobe
    && muxed_low_bus_oe && muxed_low_bus_o == $past(core_addr[7:0])
    ##1 !addr_latch_strobe && !muxed_low_bus_oe && !read_strobe_n)
    else $error("read phases wrong");
  wr_phase_a: assert property (
    take && wr_k && config_strap |=> addr_latch_strobe
    ##1 (!store_strobe_n && muxed_low_bus_oe) [*2]
    ##0 muxed_low_bus_o == $past(core_wdata, 3))
    else $error("write phases wrong");
  rd_wait_a: assert property (
    !read_strobe_n && !$past(read_strobe_n)
    |=> read_strobe_n == $past(ready))
    else $error("wait state handling wrong");
  // ==========================================================
  // Interrupts and halt
  ack_float_a: assert property (
    !irq_ack_n |-> !muxed_low_bus_oe && !mid_addr_oe && read_strobe_n
    && !hold_grant)
    else $error("acknowledge drives bus");
  ack_ptr_a: assert property (
    core_irq_take && !$past(irq_ack_n, 2)
    |-> core_irq_ptr == {core_rdata, 2'b00})
    else $error("vector pointer wrong");
  nmi_vec_a: assert property (
    core_irq_take && $past(irq_ack_n, 2) && $past(irq_ack_n, 3)
    |-> core_irq_ptr == 10'h008)
    else $error("nmi vector wrong");
  halt_ale_a: assert property (
    take && core_kind == crb_pkg::CS_HALT && config_strap
    |=> !addr_latch_strobe ##1 addr_latch_strobe
    && {io_or_mem_sel, xcvr_dir, status_zero_min} == 3'h7)
    else $error("halt strobe wrong");
  cover property (core_irq_take && !$past(irq_ack_n, 2));
  cover property (!read_strobe_n && !ready);
  cover property (hold_grant);
endmodule
bind crb_bus_ctrl crb_bus_ctrl_chk i_crb_bus_ctrl_chk (.*);
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the bus and interrupt control block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, resetn = 1'b0, cpu_reset = 1'b1, config_strap = 1'b1;
  logic nonmaskable_irq = 1'b0, maskable_irq_req = 1'b0, hold_req = 1'b0;
  logic wait_release_n = 1'b1, core_req = 1'b0, core_lock_prefix = 1'b0;
  logic core_lock_last = 1'b0, core_boundary = 1'b0, core_if_wr = 1'b0;
  logic core_if_val = 1'b0, core_waiting = 1'b0, ready;
  logic [2:0] core_kind = 3'h0;
  logic [19:0] core_addr = 20'h00000;
  logic [7:0] core_wdata = 8'h00, muxed_low_bus_i, muxed_low_bus_o, core_rdata;
  logic [3:0] wt = 4'h0;
  logic muxed_low_bus_oe, ctl_oe, addr_latch_strobe, hold_grant;
  logic read_strobe_n, store_strobe_n, irq_ack_n, bus_exclusive_n;
  logic core_ready, core_done, core_start, irq_enable_flag, core_if_pushed;
  logic core_irq_take, core_wait_done;
  logic [9:0] core_irq_ptr;
  int err_total = 0, cmp_count = 0, acks = 0, grants = 0, ales = 0;
  always #5 clk = ~clk;
  always @(negedge irq_ack_n) acks++;
  always @(posedge hold_grant) grants++;
  always @(posedge addr_latch_strobe) ales++;
  crb_bus_ctrl i_crb_bus_ctrl (.*, .req_grant_line_i(1'b1),
    .req_grant_line_o(), .req_grant_line_oe(), .mid_addr_bus(),
    .mid_addr_oe(), .high_addr_status(), .high_addr_oe(),
    .io_or_mem_sel(), .xcvr_dir(), .xcvr_enable_n(), .status_zero_min(),
    .cycle_status(), .cycle_status_oe(), .bus_exclusive_oe(),
    .core_seg(2'h0));
  crb_mem_model i_crb_mem_model (.clk, .ad_o(muxed_low_bus_o),
    .ale(addr_latch_strobe), .rd_n(read_strobe_n), .wr_n(store_strobe_n),
    .ack_n(irq_ack_n), .waits(wt), .vtype(8'h21), .ad_i(muxed_low_bus_i),
    .rdy(ready));
  // ==========================================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic pulse_bnd();
    core_boundary = 1'b1;
    cyc(1);
    core_boundary = 1'b0;
  endtask
  task automatic set_flag();
    core_if_val = 1'b1;
    core_if_wr = 1'b1;
    cyc(1);
    core_if_wr = 1'b0;
  endtask
  task automatic wtake(output int n);
    for (n = 0; !core_irq_take && n < 30; n++) cyc(1);
  endtask
  // Request is held until the edge that takes it
  task automatic req(input logic [2:0] k, input logic [7:0] a, d);
    core_kind = k;
    core_addr = {12'h000, a};
    core_wdata = d;
    core_req = 1'b1;
    while (!core_ready) cyc(1);
    cyc(1);
    core_req = 1'b0;
  endtask
  task automatic bus(input logic [2:0] k, input logic [7:0] a, d,
    input logic [3:0] w);
    int n;
    wt = w;
    req(k, a, d);
    for (n = 0; !core_done && n < 30; n++) cyc(1);
    chk("cycle clocks", 4 + w, n);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset(input int h);
    int n;
    cpu_reset = 1'b1;
    hold_req = 1'b1;
    cyc(h);
    chk("reset outputs", 0, {muxed_low_bus_oe, ctl_oe, hold_grant});
    cpu_reset = 1'b0;
    nonmaskable_irq = 1'b1;
    for (n = 0; !core_start && n < 30; n++) cyc(1);
    nonmaskable_irq = 1'b0;
    chk("start delay", 1, n >= 7 && n <= 11);
    cyc(3);
    chk("hold first", 2'b10, {hold_grant, core_ready});
    hold_req = 1'b0;
    cyc(3);
    $display("reset test done");
  endtask
  task automatic t_maskable_irq_req();
    int n, a, g;
    maskable_irq_req = 1'b1;
    cyc(1);
    pulse_bnd();
    wtake(n);
    chk("masked", 30, n);
    set_flag();
    nonmaskable_irq = 1'b1;
    cyc(4);
    a = acks;
    pulse_bnd();
    wtake(n);
    chk("nmi vector", 10'h008, core_irq_ptr);
    chk("nmi no ack", a, acks);
    nonmaskable_irq = 1'b0;
    set_flag();
    pulse_bnd();
    cyc(2);
    hold_req = 1'b1;
    g = grants;
    wtake(n);
    maskable_irq_req = 1'b0;
    chk("ack cycles", a + 2, acks);
    chk("no grant", g, grants);
    chk("vector", 10'h084, core_irq_ptr);
    chk("flag", 2'b01, {irq_enable_flag, core_if_pushed});
    cyc(3);
    chk("grant after", 1, hold_grant);
    hold_req = 1'b0;
    cyc(3);
    $display("interrupt test done");
  endtask
  task automatic t_rw();
    bus(crb_pkg::CS_MEM_WR, 8'h03, 8'ha5, 4'h0);
    bus(crb_pkg::CS_IO_WR, 8'h0c, 8'h5a, 4'h1);
    bus(crb_pkg::CS_MEM_RD, 8'h03, 8'h00, 4'h2);
    chk("mem read", 8'ha5, core_rdata);
    bus(crb_pkg::CS_IO_RD, 8'h0c, 8'h00, 4'h0);
    chk("io read", 8'h5a, core_rdata);
    bus(crb_pkg::CS_FETCH, 8'h03, 8'h00, 4'h1);
    chk("fetch", 8'ha5, core_rdata);
    $display("read write test done");
  endtask
  task automatic t_halt();
    int n, a;
    a = ales;
    req(crb_pkg::CS_HALT, 8'h00, 8'h00);
    cyc(3);
    chk("halt strobe", a + 1, ales);
    hold_req = 1'b1;
    cyc(3);
    chk("halt hold", 1, hold_grant);
    hold_req = 1'b0;
    cyc(4);
    chk("halt again", a + 2, ales);
    chk("still halted", 0, core_ready);
    nonmaskable_irq = 1'b1;
    wtake(n);
    chk("halt exit", 10'h008, core_irq_ptr);
    nonmaskable_irq = 1'b0;
    cyc(2);
    nonmaskable_irq = 1'b1;
    cyc(4);
    nonmaskable_irq = 1'b0;
    pulse_bnd();
    wtake(n);
    chk("second edge", 1, n < 30);
    $display("halt test done");
  endtask
  task automatic t_misc();
    config_strap = 1'b0;
    core_lock_prefix = 1'b1;
    cyc(1);
    core_lock_prefix = 1'b0;
    chk("lock on", 0, bus_exclusive_n);
    core_lock_last = 1'b1;
    bus(crb_pkg::CS_MEM_WR, 8'h05, 8'h3c, 4'h0);
    core_lock_last = 1'b0;
    cyc(1);
    chk("lock off", 1, bus_exclusive_n);
    config_strap = 1'b1;
    core_waiting = 1'b1;
    cyc(3);
    chk("wait held", 0, core_wait_done);
    wait_release_n = 1'b0;
    cyc(2);
    chk("wait released", 1, core_wait_done);
    core_waiting = 1'b0;
    wait_release_n = 1'b1;
    cyc(2);
    $display("lock and wait test done");
  endtask
  // ==========================================================
  // Sequence and watchdog
  initial begin
    cyc(16);
    resetn = 1'b1;
    t_reset(5000);
    t_maskable_irq_req();
    t_rw();
    t_halt();
    t_misc();
    t_reset(6);
    t_rw();
    finish_test();
  end
  // About 50 us of work; 200 us means a hang
  initial begin
    #200us;
    err_total++;
    finish_test();
  end
endmodule
`default_nettype wire
